// ### conv_device.sv
/*
  Converter control: conversion sequencing, output coding with clipping,
  GPIO and clock output.
  Assumes the filter supplies a wide signed sample and a new-sample strobe;
  pins and sync/powerdown pin are asynchronous and synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Wake in standby starts one settled conversion; code skips the settle count after wake
// - First result after wake is settled; code gives it after one period, without the settle count
// - Host sends standby after each one-shot read
// - Convert continuously after sync, mux, wake
// - Data-ready spacing equals one over rate
// - Step settling five, three, two, else one
// - Host resyncs or discards mixed result
// - Result is 24-bit two's complement
// - Clip at 7fffff and 800000
// - Zero gives 000000, one LSB 000001
// - Each pin has its own direction bit
// - Readback shows pin levels; writes drive outputs
// - Small variant ignores missing pins two, three
// - GPIO works in standby and powerdown
// - Reset: inputs, pin zero clock output
// - Two-bit field picks clock divide
// - Standby leaves clock output running
// - Host disables clock output if unneeded
// - Sync aborts, restarts, holds ready high
module conv_device #(
  parameter int unsigned pins = 4 // 4 large variant, 2 small
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  conv_if.device link, // Host link
  input wire logic signed [31:0] filter_sample, // Filter output, wide
  input wire logic filter_new, // Filter sample strobe
  input wire logic sync_powerdown_pin, // Sync pin, high aborts
  input wire logic [3:0] gpio_in, // Pin levels
  output logic [3:0] gpio_out, // Pin drive value
  output logic [3:0] gpio_oe, // Pin drive enable
  output logic standby // Converter in standby
);
  typedef enum logic [1:0] {st_standby, st_settle, st_run} state_type;
  state_type state_q;
  logic [3:0] dir_q, val_q, pin_s1_q, pin_s2_q, pinv_q;
  logic [1:0] clkout_q;
  // Three bits so the slowest select still toggles four clocks apart
  logic [2:0] div_q;
  logic [3:0] rate_q;
  logic sync_s1_q, sync_s2_q;
  logic [2:0] settle_q;
  logic [31:0] tick_q;
  logic data_ready_n_n_q, valid_q, standby_q, one_shot_q;
  logic [23:0] result_q, rdata_q;
  logic [3:0] oe_q, out_q;

  wire [31:0] period = (rate_q == conv_pkg::rate_30k) ? conv_pkg::period_30k :
    (conv_pkg::period_30k << rate_q);
  wire tick_end = (tick_q >= period - 32'h1);
  wire [2:0] settle_need = (rate_q == conv_pkg::rate_30k) ? conv_pkg::settle_30k :
    (rate_q == conv_pkg::rate_15k) ? conv_pkg::settle_15k :
    (rate_q == conv_pkg::rate_7k5) ? conv_pkg::settle_7k5 : conv_pkg::settle_slow;
  wire hold = sync_s2_q || (link.cmd == conv_pkg::cmd_sync);
  wire start = (state_q == st_standby) && (link.cmd == conv_pkg::cmd_wake);
  // Saturate instead of wrapping the wide filter word
  wire over = filter_sample > $signed({8'h00, conv_pkg::code_pos_max});
  wire under = filter_sample < $signed({8'hff, conv_pkg::code_neg_min});
  wire [23:0] coded = over ? conv_pkg::code_pos_max : under ? conv_pkg::code_neg_min :
    filter_sample[23:0];
  wire conv_done = (state_q != st_standby) && !hold && tick_end;
  wire [3:0] pin_mask = (pins == 4) ? 4'hf : 4'h3;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      sync_s1_q <= sync_powerdown_pin;
      sync_s2_q <= sync_s1_q;
      pin_s1_q <= gpio_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_q <= conv_pkg::dir_reset;
      val_q <= conv_pkg::val_reset;
      clkout_q <= conv_pkg::clkout_reset;
      rate_q <= conv_pkg::rate_30k;
    end else if (link.cfg_we) begin
      dir_q <= link.cfg_dir;
      val_q <= link.cfg_val;
      clkout_q <= link.cfg_clkout;
      rate_q <= link.cfg_rate;
    end
  end

  // Sequencer; outside standby, sample filter output at each filter strobe and at period ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= st_standby;
      tick_q <= 32'h0;
      settle_q <= 3'h0;
      data_ready_n_n_q <= 1'b1;
      result_q <= 24'h0;
      standby_q <= 1'b1;
      one_shot_q <= 1'b0;
    end else if (hold) begin
      state_q <= st_settle;
      tick_q <= 32'h0;
      settle_q <= 3'h0;
      data_ready_n_n_q <= 1'b1;
      standby_q <= 1'b0;
      one_shot_q <= 1'b0;
    end else if (start) begin
      state_q <= st_settle;
      tick_q <= 32'h0;
      settle_q <= 3'h0;
      data_ready_n_n_q <= 1'b1;
      standby_q <= 1'b0;
      one_shot_q <= 1'b1;
    end else if (link.cmd == conv_pkg::cmd_standby) begin
      state_q <= st_standby;
      standby_q <= 1'b1; // clock output untouched
    end else if (state_q != st_standby) begin
      tick_q <= tick_end ? 32'h0 : tick_q + 32'h1;
      if (filter_new || conv_done) begin
        result_q <= coded;
      end
      if (conv_done) begin
        if (state_q == st_settle && settle_q + 3'h1 < settle_need && !one_shot_q) begin
          settle_q <= settle_q + 3'h1;
        end else begin
          // One-shot results appear after the first period; restart results only once settled
          state_q <= st_run;
          data_ready_n_n_q <= 1'b0;
        end
      end else if (link.read_req) begin
        data_ready_n_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 24'h0;
      valid_q <= 1'b0;
      pinv_q <= 4'h0;
      div_q <= 3'h0;
      oe_q <= 4'h1;
      out_q <= 4'h0;
    end else begin
      valid_q <= link.read_req;
      if (link.read_req) begin
        rdata_q <= result_q;
      end
      pinv_q <= pin_s2_q & pin_mask;
      div_q <= div_q + 3'h1;
      // GPIO logic ignores standby state entirely
      oe_q <= ({~dir_q[3:1], clkout_q != conv_pkg::clkout_off || !dir_q[0]}) & pin_mask;
      out_q[3:1] <= val_q[3:1] & pin_mask[3:1];
      unique case (clkout_q)
        conv_pkg::clkout_off: out_q[0] <= val_q[0];
        conv_pkg::clkout_div1: out_q[0] <= ~out_q[0];
        conv_pkg::clkout_div2: out_q[0] <= div_q[1];
        conv_pkg::clkout_div4: out_q[0] <= div_q[2];
      endcase
    end
  end

  assign link.data_ready_n = data_ready_n_n_q;
  assign link.read_data = rdata_q;
  assign link.read_valid = valid_q;
  assign link.pin_value_bits = pinv_q;
  assign gpio_out = out_q;
  assign gpio_oe = oe_q;
  assign standby = standby_q;
endmodule
`default_nettype wire

// ### conv_pkg.sv
/*
  Shared constants for the converter control block and its host end.
  Assumes one 40 MHz clock shared by both ends.
*/
`default_nettype none
package conv_pkg;
  localparam int unsigned clk_hz = 40000000;
  localparam int unsigned data_w = 24;
  localparam int unsigned gpio_n = 4;
  localparam int unsigned rate_w = 4;
  localparam logic [23:0] code_pos_max = 24'h7fffff;
  localparam logic [23:0] code_neg_min = 24'h800000;
  // Settling in data-ready periods at the three fastest rates, one period at all slower rates
  localparam logic [3:0] rate_30k = 4'h0;
  localparam logic [3:0] rate_15k = 4'h1;
  localparam logic [3:0] rate_7k5 = 4'h2;
  localparam logic [2:0] settle_30k = 3'h5;
  localparam logic [2:0] settle_15k = 3'h3;
  localparam logic [2:0] settle_7k5 = 3'h2;
  localparam logic [2:0] settle_slow = 3'h1;
  // Data-ready period per rate code, in clk cycles (clk_hz / rate)
  localparam int unsigned period_30k = clk_hz / 30000;
  localparam int unsigned period_base = clk_hz / 3750;
  localparam int unsigned period_w = 32;
  // Clock-output select encodings
  localparam logic [1:0] clkout_off = 2'h0;
  localparam logic [1:0] clkout_div1 = 2'h1;
  localparam logic [1:0] clkout_div2 = 2'h2;
  localparam logic [1:0] clkout_div4 = 2'h3;
  localparam logic [1:0] clkout_reset = clkout_div1;
  localparam logic [3:0] dir_reset = 4'hf;
  localparam logic [3:0] val_reset = 4'h0;
  typedef enum logic [1:0] {cmd_none, cmd_wake, cmd_standby, cmd_sync} cmd_type;
endpackage
`default_nettype wire

// ### conv_if.sv
/*
  Link between host and converter control: commands, data-ready, result
  read, configuration writes and GPIO readback.
  Assumes both ends share clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface conv_if;
  conv_pkg::cmd_type cmd;
  logic read_req;
  logic [23:0] read_data;
  logic read_valid;
  logic data_ready_n;
  logic cfg_we;
  logic [3:0] cfg_dir;
  logic [3:0] cfg_val;
  logic [1:0] cfg_clkout;
  logic [3:0] cfg_rate;
  logic [3:0] pin_value_bits;
  modport device (input cmd, read_req, cfg_we, cfg_dir, cfg_val, cfg_clkout, cfg_rate,
    output read_data, read_valid, data_ready_n, pin_value_bits);
  modport host (output cmd, read_req, cfg_we, cfg_dir, cfg_val, cfg_clkout, cfg_rate,
    input read_data, read_valid, data_ready_n, pin_value_bits);
endinterface
`default_nettype wire

// ### conv_host.sv
/*
  Host end: one-shot or continuous measurement sequencing.
  Assumes the device end on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module conv_host (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  conv_if.host link, // Device link
  input wire logic measure, // Pulse: request one result
  input wire logic one_shot, // Standby after each read
  input wire logic input_stepped, // Pulse: input changed
  input wire logic cfg_we, // Pulse: write configuration
  input wire logic [3:0] cfg_dir, // Direction bits
  input wire logic [3:0] cfg_val, // Pin values
  input wire logic [1:0] cfg_clkout, // Clock-output select
  input wire logic [3:0] cfg_rate, // Rate code
  output logic [23:0] result, // Last result
  output logic result_valid // Pulse: result fresh
);
  typedef enum logic [1:0] {h_idle, h_wait, h_read, h_done} hstate_type;
  hstate_type st_q;
  conv_pkg::cmd_type cmd_q;
  logic rd_q, we_q, valid_q, seen_high_q, asleep_q;
  logic [3:0] dir_q, val_q, rate_q;
  logic [1:0] clk_q;
  logic [23:0] res_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= h_idle;
      cmd_q <= conv_pkg::cmd_none;
      rd_q <= 1'b0;
      we_q <= 1'b0;
      valid_q <= 1'b0;
      seen_high_q <= 1'b0;
      asleep_q <= 1'b1;
      res_q <= 24'h0;
      dir_q <= conv_pkg::dir_reset;
      val_q <= conv_pkg::val_reset;
      clk_q <= conv_pkg::clkout_reset; // user may write off
      rate_q <= conv_pkg::rate_30k;
    end else begin
      cmd_q <= conv_pkg::cmd_none;
      rd_q <= 1'b0;
      valid_q <= 1'b0;
      we_q <= cfg_we;
      if (cfg_we) begin
        dir_q <= cfg_dir;
        val_q <= cfg_val;
        clk_q <= cfg_clkout;
        rate_q <= cfg_rate;
      end
      if (input_stepped) begin
        cmd_q <= conv_pkg::cmd_sync;
        seen_high_q <= 1'b0;
        asleep_q <= 1'b0;
      end
      unique case (st_q)
        h_idle: if (measure) begin
          // Wake only from standby; a running converter would ignore it
          if (asleep_q) begin
            cmd_q <= conv_pkg::cmd_wake;
          end
          asleep_q <= 1'b0;
          seen_high_q <= 1'b0;
          st_q <= h_wait;
        end
        h_wait: begin
          if (link.data_ready_n) begin
            seen_high_q <= 1'b1;
          end
          if (seen_high_q && !link.data_ready_n && !input_stepped) begin
            rd_q <= 1'b1;
            st_q <= h_read;
          end
        end
        h_read: if (link.read_valid) begin
          res_q <= link.read_data;
          valid_q <= 1'b1;
          st_q <= h_done;
        end
        h_done: begin
          if (one_shot) begin
            cmd_q <= conv_pkg::cmd_standby;
            asleep_q <= 1'b1;
          end
          st_q <= h_idle;
        end
      endcase
    end
  end

  assign link.cmd = cmd_q;
  assign link.read_req = rd_q;
  assign link.cfg_we = we_q;
  assign link.cfg_dir = dir_q;
  assign link.cfg_val = val_q;
  assign link.cfg_clkout = clk_q;
  assign link.cfg_rate = rate_q;
  assign result = res_q;
  assign result_valid = valid_q;
endmodule
`default_nettype wire

// ### conv_asserts.sv
/*
  Checker for the host-to-converter link.
  Assumes it is instantiated beside the link, with the link signals wired to its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module conv_asserts (
  input wire logic clk, // Clock
  input wire logic reset, // Async reset, high
  input wire conv_pkg::cmd_type cmd, // Host command
  input wire logic read_req, // Read request
  input wire logic read_valid, // Read answer
  input wire logic [23:0] read_data, // Read word
  input wire logic data_ready_n // Data ready, low
);
  localparam int unsigned min_gap = conv_pkg::period_30k - 4;
  logic rdy_q;
  logic [31:0] gap_q;
  // Gap restarts on any command too, so a resync never reads as a short period
  wire logic restart = cmd != conv_pkg::cmd_none || (!data_ready_n && rdy_q);
  wire logic [31:0] gap_d = restart ? 32'h0 : gap_q + 32'h1;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdy_q <= 1'b1;
      gap_q <= 32'h0;
    end else begin
      rdy_q <= data_ready_n;
      gap_q <= gap_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_READ_ANSWER: assert property (read_req |=> read_valid)
    else $error("read request not answered next cycle");
  AST_VALID_CAUSE: assert property (read_valid |-> $past(read_req))
    else $error("read answer without request");
  AST_READ_ON_READY: assert property (read_req |-> !data_ready_n)
    else $error("read issued before data ready");
  AST_READY_HOLDS: assert property ((!data_ready_n && !read_req
    && cmd == conv_pkg::cmd_none) |=> !data_ready_n)
    else $error("data ready withdrawn without cause");
  AST_SYNC_HOLD: assert property (cmd == conv_pkg::cmd_sync |=> data_ready_n [*8])
    else $error("data ready low right after sync");
  AST_WAKE_SETTLE: assert property (cmd == conv_pkg::cmd_wake |=> data_ready_n [*8])
    else $error("data ready low right after wake");
  AST_PERIOD: assert property ($fell(data_ready_n) |-> gap_q >= min_gap)
    else $error("data ready period too short");
  AST_DATA_HELD: assert property (!read_valid |-> $stable(read_data))
    else $error("read word changed outside a read");
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Testbench: host and converter ends joined by the link, driven at the host.
  Assumes the 40 MHz clock and rate code 0 throughout.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic measure = 1'b0;
  logic one_shot = 1'b1;
  logic input_stepped = 1'b0;
  logic cfg_we = 1'b0;
  logic [3:0] cfg_dir = 4'hf;
  logic [3:0] cfg_val = 4'h0;
  logic [1:0] cfg_clkout = 2'h1;
  logic signed [31:0] sample = 32'h0;
  logic filter_new = 1'b0;
  logic [3:0] ext = 4'h0;
  logic [3:0] gpio_out;
  logic [3:0] gpio_oe;
  logic standby;
  logic result_valid;
  logic [23:0] result;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int i;
  int n;
  // Pin level resolved from the drive enable and the outside level
  wire [3:0] pins = (gpio_oe & gpio_out) | (~gpio_oe & ext);
  always #12.5 clk = ~clk;
  conv_if link ();
  conv_device #(.pins(4)) u_conv_device (.clk(clk), .reset(reset), .link(link.device),
    .filter_sample(sample), .filter_new(filter_new), .sync_powerdown_pin(1'b0),
    .gpio_in(pins), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .standby(standby));
  conv_host u_conv_host (.clk(clk), .reset(reset), .link(link.host), .measure(measure),
    .one_shot(one_shot), .input_stepped(input_stepped), .cfg_we(cfg_we), .cfg_dir(cfg_dir),
    .cfg_val(cfg_val), .cfg_clkout(cfg_clkout), .cfg_rate(4'h0), .result(result),
    .result_valid(result_valid));
  conv_asserts u_conv_asserts (.clk(clk), .reset(reset), .cmd(link.cmd),
    .read_req(link.read_req), .read_valid(link.read_valid), .read_data(link.read_data),
    .data_ready_n(link.data_ready_n));
  task automatic results;
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    filter_new <= #2 (cyc % 64 == 0);
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic get(input logic signed [31:0] s, input logic [23:0] exp);
    int k;
    // Let the host leave its done state, else the measure pulse is lost
    tick(2);
    sample = s;
    measure = 1'b1;
    tick(1);
    measure = 1'b0;
    for (k = 0; k < 20000 && result_valid !== 1'b1; k++) tick(1);
    check(result, exp);
  endtask
  task automatic cfg(input logic [3:0] dir, input logic [3:0] val, input logic [1:0] ck);
    cfg_dir = dir;
    cfg_val = val;
    cfg_clkout = ck;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(8);
  endtask
  // Cycles between two changes of pin zero, capped so a dead pin cannot hang
  task automatic half(output int h);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = gpio_out[0];
      h = 0;
      while (gpio_out[0] === v && h < 20) begin
        tick(1);
        h++;
      end
    end
  endtask
  localparam logic [31:0] vals [5] = '{32'h0, 32'h1, 32'hffffffff, 32'h00800000, 32'hff7fffff};
  localparam logic [23:0] exps [5] = '{24'h0, 24'h1, 24'hffffff, 24'h7fffff, 24'h800000};
  initial begin
    tick(8);
    reset = 1'b0;
    tick(2);
    check({20'h0, gpio_oe}, 24'h1);
    check({23'h0, standby}, 24'h1);
    half(n);
    check(24'(n), 24'h1);
    for (i = 1; i < 4; i++) begin
      cfg(4'hf, 4'h0, i[1:0]);
      half(n);
      check(24'(n), 24'(1 << (i - 1)));
    end
    cfg(4'h5, 4'h6, 2'h0);
    check({20'h0, gpio_oe}, 24'ha);
    check({20'h0, gpio_out & gpio_oe}, 24'h2);
    check({20'h0, link.pin_value_bits}, 24'h2);
    ext = 4'h5;
    tick(6);
    check({20'h0, link.pin_value_bits}, 24'h7);
    for (i = 0; i < 5; i++) get(vals[i], exps[i]);
    tick(8);
    check({23'h0, standby}, 24'h1);
    check({20'h0, gpio_out & gpio_oe}, 24'h2);
    cfg(4'h5, 4'h6, 2'h1);
    half(n);
    check(24'(n), 24'h1);
    one_shot = 1'b0;
    get(vals[3], exps[3]);
    get(vals[4], exps[4]);
    input_stepped = 1'b1;
    tick(1);
    input_stepped = 1'b0;
    get(vals[2], exps[2]);
    results();
  end
endmodule
`default_nettype wire
